// ===== rtl/dcc_handler.sv
// Detector configuration command handler with APB register access
//
// The APB register port and the register offsets were decided locally.
module dcc_handler
   import dcc_pkg::*;
#(
   parameter int SETTLE_CYC = DCC_SETTLE_CYC,
   parameter int TIMEOUT_CYC = DCC_SETTLE_TIMEOUT,
   parameter logic [8:0] MASS_MAX = DCC_MASS_FINAL_DEF
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic option_fitted,
   input wire logic hv_ready,
   input wire logic [11:0] hv_measured,
   output logic [11:0] bias_dac,
   output logic anode_select,
   output logic negative_polarity,
   output logic bias_indicator_lamp,
   output logic [2:0] noise_floor_level
);
   typedef enum logic [2:0] {
      DCC_S_IDLE = 3'b001,
      DCC_S_SETTLE = 3'b010,
      DCC_S_DONE = 3'b100
   } dcc_state_t;

   dcc_state_t state_reg;
   dcc_det_t det_reg;
   logic [2:0] nf_reg;
   logic [7:0] status_reg;
   logic [23:0] resp_reg;
   logic resp_valid_reg;
   logic [7:0] merr_reg;
   logic [7:0] mass_init_reg;
   logic [8:0] mass_final_reg;
   logic [4:0] steps_reg;
   logic [2:0] rdy_sync;
   logic [2:0] fit_sync;
   logic rdy_reg;
   logic fit_reg;
   logic [31:0] prdata_next;
   logic wr_acc;
   logic rd_acc;
   logic cmd_go;
   dcc_cmd_t cmd;
   logic settle_start;
   logic settle_done;
   logic settle_fail;
   logic bias_ok;
   logic [15:0] bias_val;
   logic [15:0] points;

   //=======================================================================
   // Pin synchronisers: a change counts when stages two and three agree
   always_ff @(posedge clk) begin
      if (srst) begin
         rdy_sync <= 3'b000;
         fit_sync <= 3'b000;
      end else begin
         rdy_sync <= {rdy_sync[1:0], hv_ready};
         fit_sync <= {fit_sync[1:0], option_fitted};
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         rdy_reg <= 1'b0;
         fit_reg <= 1'b0;
      end else begin
         if (rdy_sync[1] == rdy_sync[2]) begin
            rdy_reg <= rdy_sync[2];
         end
         if (fit_sync[1] == fit_sync[2]) begin
            fit_reg <= fit_sync[2];
         end
      end
   end

   //=======================================================================
   // APB: zero-wait slave, command writes refused while a bias settles
   assign wr_acc = psel && penable && pwrite;
   assign rd_acc = psel && penable && !pwrite;
   assign cmd = dcc_cmd_t'({pwdata[DCC_OP_LSB +: 3],
      pwdata[DCC_FORM_LSB +: 2], pwdata[DCC_INT_BIT],
      pwdata[DCC_VAL_LSB +: 16]});
   assign cmd_go = wr_acc && (paddr == DCC_CMD_OFS) &&
      (state_reg == DCC_S_IDLE);
   // Ready and error come from flops; ready is low only while in reset
   always_ff @(posedge clk) begin
      if (srst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= 1'b1;
         pslverr <= 1'b0;
      end
   end

   // Read mux; unmapped addresses read zero
   always_comb begin
      prdata_next = 32'h0000_0000;
      case (paddr)
         DCC_STAT_OFS: begin
            prdata_next[7:0] = status_reg;
            prdata_next[DCC_SR_BUSY] = (state_reg != DCC_S_IDLE);
            prdata_next[DCC_SR_VALID] = resp_valid_reg;
            prdata_next[DCC_SR_FITTED] = fit_reg;
            prdata_next[DCC_SR_ANODE] = det_reg.anode_sel;
            prdata_next[DCC_SR_NEG] = det_reg.neg_pol;
            prdata_next[DCC_SR_LAMP] = bias_indicator_lamp;
         end
         DCC_RESP_OFS: prdata_next[23:0] = resp_reg;
         DCC_BIAS_OFS: prdata_next[11:0] = det_reg.bias_set;
         DCC_NF_OFS: prdata_next[2:0] = nf_reg;
         DCC_SCAN_OFS: begin
            prdata_next[7:0] = mass_init_reg;
            prdata_next[16:8] = mass_final_reg;
            prdata_next[28:24] = steps_reg;
         end
         DCC_ERR_OFS: prdata_next[7:0] = merr_reg;
         default: prdata_next = 32'h0000_0000;
      endcase
   end

   // Registered read data, captured in the setup cycle, presented in the access cycle
   always_ff @(posedge clk) begin
      if (srst) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable) begin
         prdata <= prdata_next;
      end
   end

   // Scan range, written by the neighbouring scan set-up
   always_ff @(posedge clk) begin
      if (srst) begin
         mass_init_reg <= DCC_MASS_INIT_DEF;
         mass_final_reg <= MASS_MAX;
         steps_reg <= DCC_STEPS_DEF;
      end else if (wr_acc && paddr == DCC_SCAN_OFS) begin
         mass_init_reg <= pwdata[7:0];
         mass_final_reg <= pwdata[16:8];
         steps_reg <= pwdata[28:24];
      end
   end

   //=======================================================================
   // Bias parameter decode
   always_comb begin
      bias_val = (cmd.form == DCC_FM_DEFAULT) ? 16'(DCC_BIAS_DEF) :
         cmd.value;
      bias_ok = (cmd.form == DCC_FM_DEFAULT) ||
         (cmd.form == DCC_FM_VALUE && cmd.is_int &&
          (cmd.value == 16'h0000 ||
           (cmd.value >= 16'(DCC_BIAS_MIN) &&
            cmd.value <= 16'(DCC_BIAS_MAX))));
   end

   // Analog point count; final mass below initial mass is not checked and wraps
   assign points = 16'((16'(mass_final_reg) - 16'(mass_init_reg)) *
      16'(steps_reg) + 16'h0001);

   assign settle_start = cmd_go && cmd.op == DCC_OP_BIAS && fit_reg &&
      bias_ok;

   //=======================================================================
   // Command sequencer
   always_ff @(posedge clk) begin
      if (srst) begin
         state_reg <= DCC_S_IDLE;
      end else begin
         case (state_reg)
            DCC_S_IDLE: begin
               if (settle_start) begin
                  state_reg <= DCC_S_SETTLE;
               end
            end
            DCC_S_SETTLE: begin
               if (settle_done || settle_fail) begin
                  state_reg <= DCC_S_DONE;
               end
            end
            DCC_S_DONE: state_reg <= DCC_S_IDLE;
            default: state_reg <= DCC_S_IDLE;
         endcase
      end
   end

   // Detector path and bias
   always_ff @(posedge clk) begin
      if (srst) begin
         det_reg <= '0;
      end else if (settle_start) begin
         det_reg.bias_set <= bias_val[11:0];
         det_reg.anode_sel <= (bias_val != 16'h0000);
         det_reg.neg_pol <= (bias_val != 16'h0000);
      end
   end

   // Outputs registered from the detector state and level, one cycle behind
   always_ff @(posedge clk) begin
      if (srst) begin
         bias_dac <= 12'h000;
         anode_select <= 1'b0;
         negative_polarity <= 1'b0;
         bias_indicator_lamp <= 1'b0;
         noise_floor_level <= DCC_NF_DEF;
      end else begin
         bias_dac <= det_reg.bias_set;
         anode_select <= det_reg.anode_sel;
         negative_polarity <= det_reg.neg_pol;
         bias_indicator_lamp <= (det_reg.bias_set != 12'h000);
         noise_floor_level <= nf_reg;
      end
   end

   // Noise floor level, one setting for every measurement kind
   always_ff @(posedge clk) begin
      if (srst) begin
         nf_reg <= DCC_NF_DEF;
      end else if (cmd_go && cmd.op == DCC_OP_NOISE) begin
         if (cmd.form == DCC_FM_DEFAULT) begin
            nf_reg <= DCC_NF_DEF;
         end else if (cmd.form == DCC_FM_VALUE && cmd.is_int &&
                      cmd.value <= 16'(DCC_NF_MAX)) begin
            nf_reg <= cmd.value[2:0];
         end
      end
   end

   // Multiplier error byte: failure cause of the latest bias setting, cleared when one starts
   always_ff @(posedge clk) begin
      if (srst) begin
         merr_reg <= DCC_MERR_NONE;
      end else if (state_reg == DCC_S_SETTLE && settle_fail) begin
         merr_reg <= DCC_MERR_SETTLE;
      end else if (settle_start) begin
         merr_reg <= DCC_MERR_NONE;
      end
   end

   //=======================================================================
   // Status byte and query responses
   always_ff @(posedge clk) begin
      if (srst) begin
         status_reg <= 8'h00;
         resp_reg <= 24'h00_0000;
         resp_valid_reg <= 1'b0;
      end else if (state_reg == DCC_S_SETTLE && settle_fail) begin
         status_reg[DCC_ST_EXEC] <= 1'b1;
         resp_valid_reg <= 1'b1;
      end else if (state_reg == DCC_S_SETTLE && settle_done) begin
         resp_valid_reg <= 1'b1;
      end else if (cmd_go) begin
         status_reg <= 8'h00;
         resp_valid_reg <= 1'b1;
         resp_reg <= 24'h00_0000;
         case (cmd.op)
            DCC_OP_BIAS: begin
               if (!fit_reg) begin
                  status_reg[DCC_ST_BADCMD] <= 1'b1;
               end else if (cmd.form == DCC_FM_QUERY) begin
                  resp_reg <= {12'h000, hv_measured};
               end else if (!bias_ok) begin
                  status_reg[DCC_ST_BADPAR] <= 1'b1;
               end else begin
                  resp_valid_reg <= 1'b0;
               end
            end
            DCC_OP_OPTION: begin
               if (cmd.form == DCC_FM_QUERY) begin
                  resp_reg <= {DCC_ASCII_0 | {7'h00, fit_reg},
                     DCC_ASCII_LF, DCC_ASCII_CR};
               end else begin
                  status_reg[DCC_ST_BADPAR] <= 1'b1;
               end
            end
            DCC_OP_NOISE: begin
               if (cmd.form == DCC_FM_QUERY) begin
                  resp_reg <= {21'h00_0000, nf_reg};
               end else if (cmd.form == DCC_FM_NONE ||
                  (cmd.form == DCC_FM_VALUE && (!cmd.is_int ||
                   cmd.value > 16'(DCC_NF_MAX)))) begin
                  status_reg[DCC_ST_BADPAR] <= 1'b1;
               end
            end
            DCC_OP_POINTS: begin
               if (cmd.form == DCC_FM_QUERY) begin
                  resp_reg <= {8'h00, points};
               end else begin
                  status_reg[DCC_ST_BADPAR] <= 1'b1;
               end
            end
            DCC_OP_BIASERR: resp_reg <= {16'h0000, merr_reg};
            default: status_reg[DCC_ST_BADCMD] <= 1'b1;
         endcase
      end
   end

   //=======================================================================
   // Settling wait for multiplier and electrometer
   dcc_settle #(
      .SETTLE_CYC(SETTLE_CYC),
      .TIMEOUT_CYC(TIMEOUT_CYC)
   ) u_settle (
      .clk(clk),
      .srst(srst),
      .start(settle_start),
      .ready_sync(rdy_reg),
      .done(settle_done),
      .fail(settle_fail)
   );
endmodule // dcc_handler

// ===== rtl/dcc_pkg.sv
// Package: constants and types for the detector configuration command handler
//==========================================================================
// Summary of operation
// - Bias command accepted only with multiplier fitted, else bad-command error.
// - Bias zero: no bias, cup collector, positive polarity, lamp off, status.
// - Bias 10..2490: negative bias, multiplier anode, negative polarity, lamp on.
// - Only current magnitudes are sent, whatever the detector polarity.
// - Default marker on bias command applies 1400 volts.
// - Bias query returns magnitude measured at the high-voltage driver output.
// - Bias rejects non-integer, out-of-range or missing parameter as errors.
// - Status bit 3 flags bias failure; cause kept in multiplier error byte.
// - Bias status byte sent only after multiplier and electrometer settle, or after the settle timeout.
// - Power-on reset selects cup collector with zero bias.
// - Bias lamp follows bias state at all times.
// - Option query answers ASCII 1 or 0, then line feed, carriage return.
// - Option command accepted only as a query; else bad-parameter error.
// - Noise floor accepts 0..7; lower means less bandwidth, more averaging.
// - Noise floor is 4 at power-up and on default marker.
// - All measurement kinds share one noise-floor setting.
// - Noise-floor query returns the level in use.
// - Noise floor missing, non-integer or out-of-range parameter flags error.
// - Point count is (final minus initial mass) times steps per amu plus one.
// - Each point is four bytes; count excludes trailing total-pressure value.
// - Point-count command accepts only the query; missing parameter is error.
package dcc_pkg;

   //=======================================================================
   // Register map (APB byte addresses)
   localparam logic [7:0] DCC_CMD_OFS = 8'h00;
   localparam logic [7:0] DCC_STAT_OFS = 8'h04;
   localparam logic [7:0] DCC_RESP_OFS = 8'h08;
   localparam logic [7:0] DCC_BIAS_OFS = 8'h0c;
   localparam logic [7:0] DCC_NF_OFS = 8'h10;
   localparam logic [7:0] DCC_SCAN_OFS = 8'h14;
   localparam logic [7:0] DCC_ERR_OFS = 8'h18;

   //=======================================================================
   // Command register field positions
   localparam int DCC_OP_LSB = 0;
   localparam int DCC_FORM_LSB = 4;
   localparam int DCC_INT_BIT = 6;
   localparam int DCC_VAL_LSB = 16;
   // Status byte bit positions
   localparam int DCC_ST_BADCMD = 0;
   localparam int DCC_ST_BADPAR = 1;
   localparam int DCC_ST_EXEC = 3;
   // Status register extra bits
   localparam int DCC_SR_BUSY = 8;
   localparam int DCC_SR_VALID = 9;
   localparam int DCC_SR_FITTED = 10;
   localparam int DCC_SR_ANODE = 11;
   localparam int DCC_SR_NEG = 12;
   localparam int DCC_SR_LAMP = 13;

   //=======================================================================
   // Values
   localparam logic [11:0] DCC_BIAS_MIN = 12'h00a;
   localparam logic [11:0] DCC_BIAS_MAX = 12'h9ba;
   localparam logic [11:0] DCC_BIAS_DEF = 12'h578;
   localparam logic [2:0] DCC_NF_DEF = 3'h4;
   localparam logic [2:0] DCC_NF_MAX = 3'h7;
   localparam logic [7:0] DCC_MASS_INIT_DEF = 8'h01;
   localparam logic [8:0] DCC_MASS_FINAL_DEF = 9'h064;
   localparam logic [4:0] DCC_STEPS_DEF = 5'h10;
   localparam logic [7:0] DCC_ASCII_0 = 8'h30;
   localparam logic [7:0] DCC_ASCII_LF = 8'h0a;
   localparam logic [7:0] DCC_ASCII_CR = 8'h0d;
   // Multiplier error byte codes
   localparam logic [7:0] DCC_MERR_NONE = 8'h00;
   localparam logic [7:0] DCC_MERR_SETTLE = 8'h01;

   //=======================================================================
   // Timing
   localparam int DCC_CLK_MHZ = 100;
   localparam int DCC_SETTLE_US = 100;
   localparam int DCC_SETTLE_CYC = DCC_SETTLE_US * DCC_CLK_MHZ;
   localparam int DCC_SETTLE_TIMEOUT = 2 * DCC_SETTLE_CYC;

   //=======================================================================
   // Types
   typedef enum logic [2:0] {
      DCC_OP_BIAS = 3'h0,
      DCC_OP_OPTION = 3'h1,
      DCC_OP_NOISE = 3'h2,
      DCC_OP_POINTS = 3'h3,
      DCC_OP_BIASERR = 3'h4
   } dcc_op_t;

   typedef enum logic [1:0] {
      DCC_FM_NONE = 2'h0,
      DCC_FM_VALUE = 2'h1,
      DCC_FM_DEFAULT = 2'h2,
      DCC_FM_QUERY = 2'h3
   } dcc_form_t;

   typedef struct packed {
      dcc_op_t op;
      dcc_form_t form;
      logic is_int;
      logic [15:0] value;
   } dcc_cmd_t;

   typedef struct packed {
      logic [11:0] bias_set;
      logic anode_sel;
      logic neg_pol;
   } dcc_det_t;

endpackage

// ===== rtl/dcc_settle.sv
// Settle timer: waits a minimum time, then for the analog ready level
module dcc_settle
   import dcc_pkg::*;
#(
   parameter int SETTLE_CYC = DCC_SETTLE_CYC,
   parameter int TIMEOUT_CYC = DCC_SETTLE_TIMEOUT
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic start,
   input wire logic ready_sync,
   output logic done,
   output logic fail
);
   logic [31:0] cnt_reg;
   logic run_reg;

   //=======================================================================
   // Counter runs from start; done once both time and ready are met
   always_ff @(posedge clk) begin
      if (srst || start) begin
         cnt_reg <= 32'h0000_0000;
      end else if (run_reg) begin
         cnt_reg <= cnt_reg + 32'h0000_0001;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         run_reg <= 1'b0;
      end else if (start) begin
         run_reg <= 1'b1;
      end else if (done || fail) begin
         run_reg <= 1'b0;
      end
   end

   // A supply that never reports ready is a failure, not a hang
   assign done = run_reg && !fail && ready_sync &&
      (cnt_reg >= 32'(SETTLE_CYC - 1));
   assign fail = run_reg && (cnt_reg >= 32'(TIMEOUT_CYC - 1));
endmodule // dcc_settle

// ===== tb/dcc_handler_bench.sv
// Testbench: self-checking bench for the detector command handler
module dcc_handler_bench
   import dcc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int SETTLE = 20;
   logic clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, st, resp, q;
   logic pready, pslverr, hv_ready, anode, negp, lamp;
   logic option_fitted = 1, slow = 0, stall = 0;
   logic [11:0] hv_measured, bias_dac;
   logic [2:0] nf;
   int fail_count = 0, compares = 0, cyc = 0, took, seed, v, mi, mf, sa;

   dcc_handler #(.SETTLE_CYC(SETTLE), .TIMEOUT_CYC(60),
      .MASS_MAX(DCC_MASS_FINAL_DEF)) u_dcc_handler (.clk(clk), .srst(srst),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .option_fitted(option_fitted), .hv_ready(hv_ready),
      .hv_measured(hv_measured), .bias_dac(bias_dac), .anode_select(anode),
      .negative_polarity(negp), .bias_indicator_lamp(lamp),
      .noise_floor_level(nf));
   dcc_hv_model u_dcc_hv_model (.clk(clk), .bias_dac(bias_dac), .slow(slow),
      .stall(stall), .hv_ready(hv_ready), .hv_measured(hv_measured));

   //=======================================================================
   // Clock, cycle count and watchdog
   initial begin
      forever #5 clk = ~clk;
   end
   always @(posedge clk) cyc <= cyc + 1;
   initial begin
      repeat (30000) @(posedge clk);
      fail_count++;
      summarize();
   end

   //=======================================================================
   // Shared tasks
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Pins as one word: lamp, polarity, select, bias, level
   task automatic check_pins(input int b, input int n);
      logic on;
      on = (b != 0);
      check({14'h0, lamp, negp, anode, bias_dac, nf},
         {14'h0, on, on, on, b[11:0], n[2:0]});
   endtask
   // One APB transfer; request held until pready is seen at an edge
   task automatic apb(input logic wr, input logic [7:0] a,
         input logic [31:0] d, output logic [31:0] r);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      r = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   function automatic logic [31:0] mk(dcc_op_t op, dcc_form_t fm,
         logic i, int val);
      return {val[15:0], 9'h000, i, fm, 1'b0, op};
   endfunction
   // Issue a command, poll until answered, check status byte, fetch reply
   task automatic exec(input logic [31:0] w, input logic [7:0] es);
      int n, t0;
      n = 0;
      t0 = cyc;
      apb(1'b1, DCC_CMD_OFS, w, q);
      do begin
         apb(1'b0, DCC_STAT_OFS, 0, st);
         n++;
      end while ((st[DCC_SR_VALID] !== 1'b1 || st[DCC_SR_BUSY] !== 1'b0)
         && n < 100);
      took = cyc - t0;
      check({22'h0, st[DCC_SR_VALID], st[DCC_SR_BUSY], st[7:0]},
         {22'h0, 2'b10, es});
      apb(1'b0, DCC_RESP_OFS, 0, resp);
   endtask
   task automatic summarize();
      $display("counts: %0d compares, %0d mismatches", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   //=======================================================================
   // Main sequence
   initial begin
      seed = 32'h3361;
      repeat (6) @(posedge clk);
      srst <= 1'b0;
      repeat (4) @(posedge clk);
      check_pins(0, DCC_NF_DEF);
      apb(1'b0, DCC_SCAN_OFS, 0, q);
      check(q, {3'h0, DCC_STEPS_DEF, 7'h0, DCC_MASS_FINAL_DEF,
         DCC_MASS_INIT_DEF});
      apb(1'b0, 8'h1c, 0, q);
      check(q, 32'h0);
      $display("test reset done");
      // Option answers both ways; bias refused while unfitted
      for (int i = 0; i < 2; i++) begin
         option_fitted <= i[0];
         repeat (6) @(posedge clk);
         exec(mk(DCC_OP_OPTION, DCC_FM_QUERY, 0, 0), 8'h00);
         check({8'h0, resp[23:0]}, {8'h0, DCC_ASCII_0 + 8'(i),
            DCC_ASCII_LF, DCC_ASCII_CR});
         if (i == 0)
            exec(mk(DCC_OP_BIAS, DCC_FM_VALUE, 1, 100), 8'h01);
      end
      for (int f = 0; f < 3; f++)
         exec(mk(DCC_OP_OPTION, dcc_form_t'(f), 1, 1), 8'h02);
      check_pins(0, 4);
      $display("test option done");
      // Bias: default, random magnitudes with a slow supply, edges
      exec(mk(DCC_OP_BIAS, DCC_FM_DEFAULT, 0, 0), 8'h00);
      check({31'h0, took >= SETTLE}, 32'h1);
      check_pins(1400, 4);
      apb(1'b0, DCC_BIAS_OFS, 0, q);
      check(q, {20'h0, DCC_BIAS_DEF});
      exec(mk(DCC_OP_BIAS, DCC_FM_QUERY, 0, 0), 8'h00);
      check(resp, {20'h0, hv_measured});
      for (int k = 0; k < 6; k++) begin
         v = (k == 3) ? 10 : (k == 4) ? 2490 : (k == 5) ? 0 :
            10 + (($random(seed) & 32'h7fff_ffff) % 2481);
         slow <= k[0];
         exec(mk(DCC_OP_BIAS, DCC_FM_VALUE, 1, v), 8'h00);
         check({31'h0, took >= (k[0] ? 40 : SETTLE)}, 32'h1);
         check_pins(v, 4);
      end
      exec(mk(DCC_OP_BIAS, DCC_FM_VALUE, 1, 9), 8'h02);
      exec(mk(DCC_OP_BIAS, DCC_FM_VALUE, 1, 2491), 8'h02);
      exec(mk(DCC_OP_BIAS, DCC_FM_VALUE, 0, 600), 8'h02);
      exec(mk(DCC_OP_BIAS, DCC_FM_NONE, 0, 0), 8'h02);
      check_pins(0, 4);
      stall <= 1'b1;
      exec(mk(DCC_OP_BIAS, DCC_FM_VALUE, 1, 500), 8'h08);
      apb(1'b0, DCC_ERR_OFS, 0, q);
      check(q, {24'h0, DCC_MERR_SETTLE});
      exec(mk(DCC_OP_BIASERR, DCC_FM_QUERY, 0, 0), 8'h00);
      check(resp, {24'h0, DCC_MERR_SETTLE});
      exec(mk(dcc_op_t'(3'h5), DCC_FM_QUERY, 0, 0), 8'h01);
      stall <= 1'b0;
      exec(mk(DCC_OP_BIAS, DCC_FM_VALUE, 1, 0), 8'h00);
      check_pins(0, 4);
      $display("test bias done");
      // Noise floor: every level, default, refusals
      for (int k = 0; k < 9; k++) begin
         v = (k < 8) ? k : ($random(seed) & 7);
         exec(mk(DCC_OP_NOISE, DCC_FM_VALUE, 1, v), 8'h00);
         exec(mk(DCC_OP_NOISE, DCC_FM_QUERY, 0, 0), 8'h00);
         check(resp, v);
         apb(1'b0, DCC_NF_OFS, 0, q);
         check(q, v);
         check_pins(0, v);
      end
      exec(mk(DCC_OP_NOISE, DCC_FM_DEFAULT, 0, 0), 8'h00);
      exec(mk(DCC_OP_NOISE, DCC_FM_VALUE, 1, 8), 8'h02);
      exec(mk(DCC_OP_NOISE, DCC_FM_VALUE, 0, 3), 8'h02);
      exec(mk(DCC_OP_NOISE, DCC_FM_NONE, 0, 0), 8'h02);
      check_pins(0, 4);
      $display("test noise done");
      // Point count over random spans, including a single-mass span
      for (int k = 0; k < 4; k++) begin
         mi = 1 + (($random(seed) & 32'h7fff_ffff) % 50);
         mf = (k == 0) ? mi : mi + (($random(seed) & 32'h7fff_ffff) % 50);
         sa = 1 + (($random(seed) & 32'h7fff_ffff) % 16);
         apb(1'b1, DCC_SCAN_OFS, {3'h0, sa[4:0], 7'h0, mf[8:0], mi[7:0]}, q);
         exec(mk(DCC_OP_POINTS, DCC_FM_QUERY, 0, 0), 8'h00);
         check(resp, (mf - mi) * sa + 1);
      end
      exec(mk(DCC_OP_POINTS, DCC_FM_NONE, 0, 0), 8'h02);
      $display("test points done");
      // Reset in mid-run with bias applied and level moved
      exec(mk(DCC_OP_NOISE, DCC_FM_VALUE, 1, 2), 8'h00);
      exec(mk(DCC_OP_BIAS, DCC_FM_DEFAULT, 0, 0), 8'h00);
      srst <= 1'b1;
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      repeat (2) @(posedge clk);
      check_pins(0, 4);
      $display("test reset again done");
      summarize();
   end
endmodule // dcc_handler_bench

// ===== tb/dcc_handler_checker.sv
// Checker: port-level assertions for the detector command handler
module dcc_handler_checker
   import dcc_pkg::*;
#(
   parameter int SETTLE_CYC = DCC_SETTLE_CYC,
   parameter int TIMEOUT_CYC = DCC_SETTLE_TIMEOUT,
   parameter logic [8:0] MASS_MAX = DCC_MASS_FINAL_DEF
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic option_fitted,
   input wire logic hv_ready,
   input wire logic [11:0] hv_measured,
   input wire logic [11:0] bias_dac,
   input wire logic anode_select,
   input wire logic negative_polarity,
   input wire logic bias_indicator_lamp,
   input wire logic [2:0] noise_floor_level
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk); endclocking
   default disable iff (srst);

   //=======================================================================
   // Helpers
   logic [3:0] wr_hist_reg;
   // Recent command writes; the level may move only shortly after one
   always_ff @(posedge clk) begin
      wr_hist_reg <= srst ? 4'h0 :
         {wr_hist_reg[2:0], psel & penable & pwrite & (paddr == DCC_CMD_OFS)};
   end
   sequence s_access;
      psel && penable;
   endsequence
   sequence s_reset_exit;
      $fell(srst);
   endsequence

   //=======================================================================
   // Assertions
   a_lamp_tracks_bias: assert property (
      bias_indicator_lamp == (bias_dac != 12'h000))
      else $error("lamp disagrees with bias");
   a_anode_with_bias: assert property (
      anode_select == (bias_dac != 12'h000))
      else $error("detector select disagrees with bias");
   a_polarity_follows: assert property (
      negative_polarity == anode_select)
      else $error("polarity disagrees with detector");
   a_bias_in_range: assert property (
      bias_dac == 12'h000 ||
      (bias_dac >= DCC_BIAS_MIN && bias_dac <= DCC_BIAS_MAX))
      else $error("bias outside legal span");
   a_reset_defaults: assert property (
      s_reset_exit |-> bias_dac == 12'h000 && !anode_select &&
      noise_floor_level == DCC_NF_DEF)
      else $error("bad state after reset");
   a_level_by_cmd: assert property (
      $changed(noise_floor_level) |-> |wr_hist_reg)
      else $error("noise level moved without command");
   a_apb_zero_wait: assert property (
      s_access |-> pready && !pslverr)
      else $error("access phase not completed cleanly");
   a_rdata_holds: assert property (
      s_access |=> $stable(prdata))
      else $error("read data moved after access");
endmodule // dcc_handler_checker

bind dcc_handler dcc_handler_checker #(.SETTLE_CYC(SETTLE_CYC),
   .TIMEOUT_CYC(TIMEOUT_CYC), .MASS_MAX(MASS_MAX)) u_dcc_handler_checker (
   .clk(clk), .srst(srst), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .option_fitted(option_fitted),
   .hv_ready(hv_ready), .hv_measured(hv_measured), .bias_dac(bias_dac),
   .anode_select(anode_select), .negative_polarity(negative_polarity),
   .bias_indicator_lamp(bias_indicator_lamp),
   .noise_floor_level(noise_floor_level));

// ===== tb/dcc_hv_model.sv
// Partner model: high-voltage multiplier supply behind the handler
module dcc_hv_model #(
   parameter int FAST_CYC = 3,
   parameter int SLOW_CYC = 40
) (
   input wire logic clk,
   input wire logic [11:0] bias_dac,
   input wire logic slow,
   input wire logic stall,
   output logic hv_ready,
   output logic [11:0] hv_measured
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [11:0] last_reg = 12'h000;
   int cnt_reg = 0;
   // Restart the ramp whenever the demanded bias moves
   always_ff @(posedge clk) begin
      last_reg <= bias_dac;
      if (bias_dac != last_reg)
         cnt_reg <= slow ? SLOW_CYC : FAST_CYC;
      else if (cnt_reg > 0)
         cnt_reg <= cnt_reg - 1;
   end
   // A stalled supply never settles, which forces the handler's timeout
   assign hv_ready = (cnt_reg == 0) && !stall;
   // Output sags slightly below demand from 256 up, so query and setting differ there
   assign hv_measured = bias_dac - (bias_dac >> 8);
endmodule // dcc_hv_model
